// ===== logic/dmc_config.sv
/*
  dram mode and timing configuration: two control registers plus an
  auxiliary and a status register over classic wishbone, refresh timing,
  read path selection, memory hole decode and address line forcing.
  assumes all request inputs are on clk_i; only the strap pin is asynchronous.
*/
// The implementer's own choice: register access over Wishbone.
// Functional notes
// - sdram trp/tras/trc per speed grade
// - refresh strobe five clocks set, four cleared
// - fast edo path shortens read leadoff
// - bursts fast only when burst timing 10
// - speculative leadoff off when bit set
// - address drive 01 10ma, 10 16ma
// - symmetry mode forces some address lines
// - hole field selects none or three holes
// - cpu hole cycles to pci, pci unclaimed
// - memory under hole is not relocated
// - hole wins inside frame buffer region
// - edo detect bit selects special timing
// - refresh rate field, zero disables
// - rate bit0 loads inverted strap at release
// - burst timing codes x444 x333 x222 x322
`timescale 1ns/1ps
module dmc_config #(
  parameter int ADDR_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic strap_address_pin_i,
  input wire logic cpu_dram_read_i,
  input wire logic bank_is_edo_i,
  input wire logic read_burst_phase_i,
  input wire logic [11:0] row_col_addr_i,
  input wire logic cpu_cycle_i,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic pci_cycle_i,
  input wire logic [ADDR_W-1:0] pci_addr_i,
  input wire logic fb_enable_i,
  input wire logic [ADDR_W-1:0] fb_base_i,
  input wire logic [ADDR_W-1:0] fb_top_i,
  output logic read_path_select_pin_o,
  output logic leadoff_pullin_o,
  output logic speculative_leadoff_en_o,
  output logic [1:0] address_drive_strength_o,
  output logic [11:0] memory_address_lines_o,
  output logic edo_detect_timing_o,
  output logic cpu_to_dram_o,
  output logic cpu_to_pci_o,
  output logic pci_claim_o,
  output logic fb_hit_o,
  output logic refresh_strobe_o,
  output logic refresh_busy_o,
  output logic [3:0] row_precharge_clks_o,
  output logic [3:0] active_to_precharge_clks_o,
  output logic [3:0] refresh_to_active_clks_o
);
  logic [7:0] ext_ctl_reg;
  logic [7:0] ctl_reg;
  logic [7:0] aux_reg;
  logic strap_meta_reg;
  logic strap_sync_reg;
  logic [2:0] rate_prev_reg;
  logic rst_seen_reg;
  logic [10:0] ref_cnt_reg;
  logic ref_due_reg;
  logic [3:0] phase_cnt_reg;
  dmc_pkg::dmc_ref_state_t ref_state_reg;

  logic wb_req;
  logic wb_wr;
  logic [9:0] wb_idx;
  logic [7:0] status_val;
  logic [1:0] hole_sel;
  logic [2:0] rate_sel;
  logic [1:0] burst_sel;
  logic [3:0] strobe_len;
  logic [3:0] trc_len;
  logic [10:0] ref_interval;
  logic ref_enabled;
  logic cpu_in_hole;
  logic pci_in_hole;
  logic cpu_in_fb;

  // address falls inside the selected hole
  function automatic logic in_hole(input logic [ADDR_W-1:0] addr, input logic [1:0] sel);
    logic [31:0] a;
    a = 32'(addr);
    unique case (sel)
      dmc_pkg::HOLE_NONE: in_hole = 1'b0;
      dmc_pkg::HOLE_LOW: in_hole = (a >= dmc_pkg::HOLE_LOW_BASE) && (a < dmc_pkg::HOLE_LOW_TOP);
      dmc_pkg::HOLE_15M: in_hole = (a >= dmc_pkg::HOLE_15M_BASE) && (a < dmc_pkg::HOLE_HI_TOP);
      dmc_pkg::HOLE_14M: in_hole = (a >= dmc_pkg::HOLE_14M_BASE) && (a < dmc_pkg::HOLE_HI_TOP);
    endcase
  endfunction

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  assign wb_idx = wb_adr_i[11:2];
  assign hole_sel = ctl_reg[dmc_pkg::CTL_HOLE_LO +: 2];
  assign rate_sel = ctl_reg[dmc_pkg::CTL_RATE_LO +: 3];
  assign burst_sel = aux_reg[dmc_pkg::AUX_BURST_LO +: 2];
  assign status_val = {5'h00, strap_sync_reg, refresh_strobe_o, refresh_busy_o};

  // refresh strobe length from its control bit
  assign strobe_len = ext_ctl_reg[dmc_pkg::EXT_STROBE_LEN] ? dmc_pkg::STROBE_LONG
                                                            : dmc_pkg::STROBE_SHORT;
  assign trc_len = aux_reg[dmc_pkg::AUX_GRADE50] ? dmc_pkg::TRC_50 : dmc_pkg::TRC_66;

  // refresh interval by bus frequency, off and reserved codes disable
  always_comb begin
    ref_enabled = 1'b1;
    ref_interval = dmc_pkg::REF_CLKS_50;
    unique case (rate_sel)
      dmc_pkg::RATE_50: ref_interval = dmc_pkg::REF_CLKS_50;
      dmc_pkg::RATE_60: ref_interval = dmc_pkg::REF_CLKS_60;
      dmc_pkg::RATE_66: ref_interval = dmc_pkg::REF_CLKS_66;
      default: ref_enabled = 1'b0;
    endcase
  end

  // hole decode and frame buffer overlap
  assign cpu_in_hole = in_hole(cpu_addr_i, hole_sel);
  assign pci_in_hole = in_hole(pci_addr_i, hole_sel);
  assign cpu_in_fb = fb_enable_i && (cpu_addr_i >= fb_base_i) && (cpu_addr_i < fb_top_i);

  // wishbone acknowledge, one cycle after the request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // read data, unmapped indices read zero, reserved bits zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_idx)
        dmc_pkg::IDX_EXT_CTL: wb_dat_o <= {24'h000000, ext_ctl_reg};
        dmc_pkg::IDX_CTL: wb_dat_o <= {24'h000000, ctl_reg};
        dmc_pkg::IDX_AUX: wb_dat_o <= {24'h000000, aux_reg};
        dmc_pkg::IDX_STATUS: wb_dat_o <= {24'h000000, status_val};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // extended control register, reserved bits masked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_ctl_reg <= dmc_pkg::EXT_CTL_RST;
    end else if (wb_wr && wb_idx == dmc_pkg::IDX_EXT_CTL) begin
      ext_ctl_reg <= wb_dat_i[7:0] & dmc_pkg::EXT_CTL_MASK;
    end
  end

  // strap synchroniser, not reset so the pin level is settled at release
  always_ff @(posedge clk_i) begin
    strap_meta_reg <= strap_address_pin_i;
    strap_sync_reg <= strap_meta_reg;
  end

  // marks the cycle after reset release for the strap capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_seen_reg <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b1;
    end
  end

  // control register; strap loads rate bit0, software writes win
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg <= dmc_pkg::CTL_RST;
    end else if (wb_wr && wb_idx == dmc_pkg::IDX_CTL) begin
      ctl_reg <= wb_dat_i[7:0] & dmc_pkg::CTL_MASK;
    end else if (!rst_seen_reg) begin
      ctl_reg[dmc_pkg::CTL_RATE_LO] <= ~strap_sync_reg;
    end
  end

  // auxiliary register: read burst timing and sdram speed grade
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_reg <= dmc_pkg::AUX_RST;
    end else if (wb_wr && wb_idx == dmc_pkg::IDX_AUX) begin
      aux_reg <= wb_dat_i[7:0] & dmc_pkg::AUX_MASK;
    end
  end

  // sdram timing per speed grade
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      row_precharge_clks_o <= dmc_pkg::TRP_66;
      active_to_precharge_clks_o <= dmc_pkg::TRAS_66;
      refresh_to_active_clks_o <= dmc_pkg::TRC_66;
    end else if (aux_reg[dmc_pkg::AUX_GRADE50]) begin
      row_precharge_clks_o <= dmc_pkg::TRP_50;
      active_to_precharge_clks_o <= dmc_pkg::TRAS_50;
      refresh_to_active_clks_o <= dmc_pkg::TRC_50;
    end else begin
      row_precharge_clks_o <= dmc_pkg::TRP_66;
      active_to_precharge_clks_o <= dmc_pkg::TRAS_66;
      refresh_to_active_clks_o <= dmc_pkg::TRC_66;
    end
  end

  // last refresh rate, a change restarts the interval at the new rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_prev_reg <= dmc_pkg::RATE_OFF;
    end else begin
      rate_prev_reg <= rate_sel;
    end
  end

  // refresh interval timer, reloads while disabled or on a rate change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_cnt_reg <= dmc_pkg::REF_CLKS_50;
    end else if (!ref_enabled || ref_cnt_reg == 11'h000 || rate_sel != rate_prev_reg) begin
      ref_cnt_reg <= ref_interval;
    end else begin
      ref_cnt_reg <= ref_cnt_reg - 11'h001;
    end
  end

  // pending refresh, a new due beats the take in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_due_reg <= 1'b0;
    end else if (ref_enabled && ref_cnt_reg == 11'h000) begin
      ref_due_reg <= 1'b1;
    end else if (!ref_enabled || ref_state_reg == dmc_pkg::REF_IDLE) begin
      ref_due_reg <= 1'b0;
    end
  end

  // refresh sequence: strobe, then hold off until refresh-to-active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_state_reg <= dmc_pkg::REF_IDLE;
      phase_cnt_reg <= 4'h0;
      refresh_strobe_o <= 1'b0;
      refresh_busy_o <= 1'b0;
    end else begin
      unique case (ref_state_reg)
        dmc_pkg::REF_IDLE: begin
          if (ref_due_reg) begin
            ref_state_reg <= dmc_pkg::REF_STROBE;
            phase_cnt_reg <= strobe_len;
            refresh_strobe_o <= 1'b1;
            refresh_busy_o <= 1'b1;
          end
        end
        dmc_pkg::REF_STROBE: begin
          if (phase_cnt_reg == 4'h1) begin
            ref_state_reg <= dmc_pkg::REF_RECOVER;
            phase_cnt_reg <= trc_len - strobe_len;
            refresh_strobe_o <= 1'b0;
          end else begin
            phase_cnt_reg <= phase_cnt_reg - 4'h1;
          end
        end
        dmc_pkg::REF_RECOVER: begin
          if (phase_cnt_reg == 4'h1) begin
            ref_state_reg <= dmc_pkg::REF_IDLE;
            refresh_busy_o <= 1'b0;
          end else begin
            phase_cnt_reg <= phase_cnt_reg - 4'h1;
          end
        end
      endcase
    end
  end

  // read path select: leadoff fast, bursts fast only at x222
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_path_select_pin_o <= 1'b0;
      leadoff_pullin_o <= 1'b0;
    end else begin
      read_path_select_pin_o <= ext_ctl_reg[dmc_pkg::EXT_FAST_EDO] && cpu_dram_read_i
                                && bank_is_edo_i
                                && (!read_burst_phase_i || burst_sel == dmc_pkg::BURST_X222);
      leadoff_pullin_o <= ext_ctl_reg[dmc_pkg::EXT_FAST_EDO] && cpu_dram_read_i
                          && bank_is_edo_i && !read_burst_phase_i;
    end
  end

  // mode outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speculative_leadoff_en_o <= 1'b0;
      address_drive_strength_o <= dmc_pkg::EXT_CTL_RST[dmc_pkg::EXT_DRIVE_LO +: 2];
      edo_detect_timing_o <= 1'b0;
    end else begin
      speculative_leadoff_en_o <= ~ext_ctl_reg[dmc_pkg::EXT_SPEC_OFF];
      address_drive_strength_o <= ext_ctl_reg[dmc_pkg::EXT_DRIVE_LO +: 2];
      edo_detect_timing_o <= ctl_reg[dmc_pkg::CTL_EDO_DET];
    end
  end

  // address lines, bits 11:10 forced to binary 10 in symmetry detect mode, the rest passed through
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      memory_address_lines_o <= 12'h000;
    end else if (ext_ctl_reg[dmc_pkg::EXT_SYM]) begin
      memory_address_lines_o <= (row_col_addr_i & ~dmc_pkg::SYM_FORCE_MASK)
                                | dmc_pkg::SYM_FORCE_VAL;
    end else begin
      memory_address_lines_o <= row_col_addr_i;
    end
  end

  // cycle steering: hole goes to pci, never remapped, pci unclaimed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_to_dram_o <= 1'b0;
      cpu_to_pci_o <= 1'b0;
      pci_claim_o <= 1'b0;
      fb_hit_o <= 1'b0;
    end else begin
      cpu_to_dram_o <= cpu_cycle_i && !cpu_in_hole;
      cpu_to_pci_o <= cpu_cycle_i && cpu_in_hole;
      pci_claim_o <= pci_cycle_i && !pci_in_hole;
      fb_hit_o <= cpu_cycle_i && cpu_in_fb && !cpu_in_hole;
    end
  end
endmodule

// ===== logic/dmc_pkg.sv
/*
  constants for the dram mode and timing configuration block: register
  indices, field positions, reset values, encodings and timing counts.
  assumes a wishbone host where each 8-bit register sits in one aligned word.
*/
package dmc_pkg;
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_EXT_CTL = 10'h056;
  localparam logic [9:0] IDX_CTL = 10'h057;
  localparam logic [9:0] IDX_AUX = 10'h05c;
  localparam logic [9:0] IDX_STATUS = 10'h05d;
  // reset values
  localparam logic [7:0] EXT_CTL_RST = 8'h52;
  localparam logic [7:0] CTL_RST = 8'h01;
  localparam logic [7:0] AUX_RST = 8'h00;
  // writable bits, reserved bits read as zero
  localparam logic [7:0] EXT_CTL_MASK = 8'h77;
  localparam logic [7:0] CTL_MASK = 8'hcf;
  localparam logic [7:0] AUX_MASK = 8'h07;
  // extended control fields
  localparam int EXT_STROBE_LEN = 6;
  localparam int EXT_FAST_EDO = 5;
  localparam int EXT_SPEC_OFF = 4;
  localparam int EXT_DRIVE_LO = 1;
  localparam int EXT_SYM = 0;
  // control fields
  localparam int CTL_HOLE_LO = 6;
  localparam int CTL_EDO_DET = 3;
  localparam int CTL_RATE_LO = 0;
  // auxiliary fields
  localparam int AUX_BURST_LO = 0;
  localparam int AUX_GRADE50 = 2;
  // encodings
  localparam logic [1:0] BURST_X222 = 2'h2;
  localparam logic [1:0] HOLE_NONE = 2'h0;
  localparam logic [1:0] HOLE_LOW = 2'h1;
  localparam logic [1:0] HOLE_15M = 2'h2;
  localparam logic [1:0] HOLE_14M = 2'h3;
  localparam logic [2:0] RATE_OFF = 3'h0;
  localparam logic [2:0] RATE_50 = 3'h1;
  localparam logic [2:0] RATE_60 = 3'h2;
  localparam logic [2:0] RATE_66 = 3'h3;
  // hole boundaries in bytes
  localparam logic [31:0] HOLE_LOW_BASE = 32'h0008_0000;
  localparam logic [31:0] HOLE_LOW_TOP = 32'h000a_0000;
  localparam logic [31:0] HOLE_14M_BASE = 32'h00e0_0000;
  localparam logic [31:0] HOLE_15M_BASE = 32'h00f0_0000;
  localparam logic [31:0] HOLE_HI_TOP = 32'h0100_0000;
  // sdram timings in host clocks per speed grade
  localparam logic [3:0] TRP_66 = 4'h3;
  localparam logic [3:0] TRAS_66 = 4'h5;
  localparam logic [3:0] TRC_66 = 4'h8;
  localparam logic [3:0] TRP_50 = 4'h3;
  localparam logic [3:0] TRAS_50 = 4'h4;
  localparam logic [3:0] TRC_50 = 4'h7;
  // refresh strobe lengths in host clocks
  localparam logic [3:0] STROBE_LONG = 4'h5;
  localparam logic [3:0] STROBE_SHORT = 4'h4;
  // refresh interval, converted to host clocks per bus frequency
  localparam int REFRESH_NS = 15600;
  localparam logic [10:0] REF_CLKS_50 = 11'(REFRESH_NS * 50 / 1000);
  localparam logic [10:0] REF_CLKS_60 = 11'(REFRESH_NS * 60 / 1000);
  localparam logic [10:0] REF_CLKS_66 = 11'(REFRESH_NS * 66 / 1000);
  // address lines forced during symmetry detection
  localparam logic [11:0] SYM_FORCE_MASK = 12'hc00;
  localparam logic [11:0] SYM_FORCE_VAL = 12'h800;

  typedef enum logic [1:0] {REF_IDLE, REF_STROBE, REF_RECOVER} dmc_ref_state_t;
endpackage

// ===== sim/dmc_config_monitor.sv
/*
  concurrent checks on the dmc_config ports, bound to every instance.
  assumes one clock clk_i and a synchronous active-high rst_i.
*/
`timescale 1ns/1ps
module dmc_config_monitor #(
  parameter int ADDR_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic cpu_dram_read_i,
  input wire logic bank_is_edo_i,
  input wire logic read_burst_phase_i,
  input wire logic cpu_cycle_i,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic read_path_select_pin_o,
  input wire logic leadoff_pullin_o,
  input wire logic cpu_to_dram_o,
  input wire logic cpu_to_pci_o,
  input wire logic fb_hit_o,
  input wire logic refresh_strobe_o,
  input wire logic refresh_busy_o,
  input wire logic [3:0] row_precharge_clks_o,
  input wire logic [3:0] active_to_precharge_clks_o,
  input wire logic [3:0] refresh_to_active_clks_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rise;
    $rose(refresh_strobe_o);
  endsequence
  sequence s_tail;
    !refresh_strobe_o or (refresh_strobe_o ##1 !refresh_strobe_o);
  endsequence
  a_strobe_len: assert property (s_rise |-> refresh_strobe_o[*4] ##1 s_tail)
    else $error("refresh strobe length wrong");
  a_busy_span: assert property (s_rise |-> refresh_busy_o[*7])
    else $error("refresh busy too short");
  a_timing_grade: assert property (row_precharge_clks_o == 4'h3 &&
    ({active_to_precharge_clks_o, refresh_to_active_clks_o} inside {8'h58, 8'h47}))
    else $error("sdram timing set wrong");
  a_pullin_cause: assert property (leadoff_pullin_o |->
    $past(cpu_dram_read_i && bank_is_edo_i && !read_burst_phase_i))
    else $error("leadoff pulled in without edo leadoff read");
  a_pullin_path: assert property (leadoff_pullin_o |-> read_path_select_pin_o)
    else $error("pull-in without fast path");
  a_hole_split: assert property ($past(cpu_cycle_i) |-> cpu_to_dram_o ^ cpu_to_pci_o)
    else $error("cpu cycle not steered to exactly one target");
  a_low_dram: assert property (cpu_cycle_i && cpu_addr_i < 'h80000 |=> cpu_to_dram_o)
    else $error("low cpu cycle not sent to dram");
  a_fb_hole: assert property (fb_hit_o |-> cpu_to_dram_o)
    else $error("frame buffer hit inside hole");
  a_rsv_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule
bind dmc_config dmc_config_monitor #(.ADDR_W(ADDR_W)) dmc_config_monitor_i (.clk_i, .rst_i,
  .wb_ack_o, .wb_dat_o, .cpu_dram_read_i, .bank_is_edo_i, .read_burst_phase_i, .cpu_cycle_i,
  .cpu_addr_i, .read_path_select_pin_o, .leadoff_pullin_o, .cpu_to_dram_o, .cpu_to_pci_o,
  .fb_hit_o, .refresh_strobe_o, .refresh_busy_o, .row_precharge_clks_o,
  .active_to_precharge_clks_o, .refresh_to_active_clks_o);

// ===== sim/dmc_rows_model.sv
/*
  dram rows model: reports edo type per bank and measures refresh strobes.
  assumes the strobe is sampled on the controller clock.
*/
`timescale 1ns/1ps
module dmc_rows_model #(
  parameter logic [3:0] EDO_BANKS = 4'h5
) (
  input wire logic clk_i,
  input wire logic [1:0] bank_i,
  input wire logic refresh_strobe_i,
  output logic bank_is_edo_o,
  output int strobe_len_o,
  output int refresh_cnt_o
);
  int run = 0;
  assign bank_is_edo_o = EDO_BANKS[bank_i];
  initial begin
    strobe_len_o = 0;
    refresh_cnt_o = 0;
  end
  // strobe length in clocks, counted per refresh
  always @(posedge clk_i) begin
    if (refresh_strobe_i) begin
      run <= run + 1;
    end else if (run != 0) begin
      strobe_len_o <= run;
      refresh_cnt_o <= refresh_cnt_o + 1;
      run <= 0;
    end
  end
endmodule

// ===== sim/dmc_config_test.sv
/*
  dmc_config bench: register, steering and refresh model compared with the design.
  assumes dmc_pkg, dmc_config, the rows model and the monitor compiled before it.
*/
`timescale 1ns/1ps
module dmc_config_test;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, strap_address_pin_i, hole;
  logic cpu_dram_read_i, bank_is_edo_i, read_burst_phase_i, cpu_cycle_i, pci_cycle_i;
  logic fb_enable_i, read_path_select_pin_o, leadoff_pullin_o, speculative_leadoff_en_o;
  logic edo_detect_timing_o, cpu_to_dram_o, cpu_to_pci_o, pci_claim_o, fb_hit_o;
  logic refresh_strobe_o, refresh_busy_o;
  logic [1:0] address_drive_strength_o, bank;
  logic [3:0] wb_sel_i, row_precharge_clks_o, active_to_precharge_clks_o;
  logic [3:0] refresh_to_active_clks_o;
  logic [11:0] wb_adr_i, row_col_addr_i, memory_address_lines_o;
  logic [31:0] wb_dat_i, wb_dat_o, cpu_addr_i, pci_addr_i, fb_base_i, fb_top_i;
  logic [7:0] q, d;
  logic [7:0] m [3] = '{8'h77, 8'hcf, 8'h07};
  logic [9:0] ix [3] = '{10'h056, 10'h057, 10'h05c};
  logic [31:0] at [5] = '{32'h0009_0000, 32'h00f8_0000, 32'h00e8_0000, 32'h0020_0000,
    32'h0004_0000};
  int errors = 0;
  int checked = 0;
  int slen, rcnt, n, k, ep;
  dmc_config dmc_config_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .strap_address_pin_i, .cpu_dram_read_i,
    .bank_is_edo_i, .read_burst_phase_i, .row_col_addr_i, .cpu_cycle_i, .cpu_addr_i,
    .pci_cycle_i, .pci_addr_i, .fb_enable_i, .fb_base_i, .fb_top_i, .read_path_select_pin_o,
    .leadoff_pullin_o, .speculative_leadoff_en_o, .address_drive_strength_o,
    .memory_address_lines_o, .edo_detect_timing_o, .cpu_to_dram_o, .cpu_to_pci_o,
    .pci_claim_o, .fb_hit_o, .refresh_strobe_o, .refresh_busy_o, .row_precharge_clks_o,
    .active_to_precharge_clks_o, .refresh_to_active_clks_o);
  dmc_rows_model dmc_rows_model_i (.clk_i, .bank_i(bank), .refresh_strobe_i(refresh_strobe_o),
    .bank_is_edo_o(bank_is_edo_i), .strobe_len_o(slen), .refresh_cnt_o(rcnt));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] v);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {i, 2'h0};
    wb_dat_i <= {24'h0, v};
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (t >= 20) errors++;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  function automatic logic in_hole(input logic [1:0] h, input logic [31:0] a);
    case (h)
      2'h1: return a >= 32'h0008_0000 && a < 32'h000a_0000;
      2'h2: return a >= 32'h00f0_0000 && a < 32'h0100_0000;
      2'h3: return a >= 32'h00e0_0000 && a < 32'h0100_0000;
      default: return 1'b0;
    endcase
  endfunction
  task automatic finish_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    finish_test;
  end
  initial begin
    void'($urandom(10));
    {wb_cyc_i, wb_stb_i, wb_we_i, cpu_dram_read_i, read_burst_phase_i, bank} = '0;
    {cpu_cycle_i, pci_cycle_i, fb_enable_i, wb_adr_i, wb_dat_i, row_col_addr_i} = '0;
    {cpu_addr_i, pci_addr_i} = '0;
    wb_sel_i = 4'h1;
    fb_base_i = 32'h00e0_0000;
    fb_top_i = 32'h0100_0000;
    strap_address_pin_i = 1'b1;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb(1'b0, 10'h056, 8'h00);
    chk(q, 8'h52);
    wb(1'b0, 10'h057, 8'h00);
    chk(q, 8'h00);
    wb(1'b0, 10'h05d, 8'h00);
    chk(q, 8'h04);
    chk({row_precharge_clks_o, active_to_precharge_clks_o, refresh_to_active_clks_o}, 12'h358);
    for (int r = 0; r < 3; r++) begin
      for (int j = 0; j < 4; j++) begin
        d = 8'($urandom);
        wb(1'b1, ix[r], d);
        wb(1'b0, ix[r], 8'h00);
        chk(q, d & m[r]);
        settle;
        if (r == 0) chk({address_drive_strength_o, speculative_leadoff_en_o},
          {d[2:1], ~d[4]});
        if (r == 1) chk(edo_detect_timing_o, d[3]);
        if (r == 2) chk({active_to_precharge_clks_o, refresh_to_active_clks_o},
          d[2] ? 8'h47 : 8'h58);
      end
    end
    wb(1'b1, 10'h3ff, 8'hff);
    wb(1'b0, 10'h3ff, 8'h00);
    chk(q, 8'h00);
    wb(1'b1, 10'h057, 8'h00);
    for (int f = 0; f < 2; f++) begin
      wb(1'b1, 10'h056, f ? 8'h22 : 8'h02);
      for (int bt = f ? 2 : 0; bt < 4; bt++) begin
        wb(1'b1, 10'h05c, 8'(bt));
        for (int c = 0; c < 4; c++) begin
          read_burst_phase_i <= c[0];
          bank <= {1'b0, c[1]};
          cpu_dram_read_i <= 1'b1;
          settle;
          k = f && !c[1];
          chk(read_path_select_pin_o, k && (!c[0] || bt == 2));
          chk(leadoff_pullin_o, k && !c[0]);
          @(posedge clk_i);
        end
      end
    end
    cpu_dram_read_i <= 1'b0;
    row_col_addr_i <= 12'($urandom);
    wb(1'b1, 10'h056, 8'h03);
    settle;
    chk(memory_address_lines_o, row_col_addr_i & 12'h3ff | 12'h800);
    wb(1'b1, 10'h056, 8'h02);
    settle;
    chk(memory_address_lines_o, row_col_addr_i);
    fb_enable_i <= 1'b1;
    for (int h = 0; h < 4; h++) begin
      wb(1'b1, 10'h057, {2'(h), 6'h0});
      for (int a = 0; a < 5; a++) begin
        {cpu_cycle_i, pci_cycle_i} <= 2'h3;
        cpu_addr_i <= at[a];
        pci_addr_i <= at[a];
        settle;
        hole = in_hole(2'(h), at[a]);
        chk({cpu_to_pci_o, cpu_to_dram_o, pci_claim_o}, {hole, !hole, !hole});
        chk(fb_hit_o, !hole && at[a] >= 32'h00e0_0000);
        @(posedge clk_i);
      end
    end
    {cpu_cycle_i, pci_cycle_i} <= 2'h0;
    for (int r = 1; r < 4; r++) begin
      wb(1'b1, 10'h057, 8'h00);
      repeat (10) @(posedge clk_i);
      wb(1'b1, 10'h056, r[0] ? 8'h42 : 8'h02);
      wb(1'b1, 10'h057, 8'(r));
      n = rcnt;
      k = 0;
      while (rcnt == n && k < 1200) begin
        @(posedge clk_i);
        k++;
      end
      chk(slen, r[0] ? 5 : 4);
      n = rcnt;
      k = 0;
      while (rcnt == n && k < 1200) begin
        @(posedge clk_i);
        k++;
      end
      ep = r == 1 ? dmc_pkg::REF_CLKS_50 : r == 2 ? dmc_pkg::REF_CLKS_60 : dmc_pkg::REF_CLKS_66;
      chk(k, ep + 1);
    end
    wb(1'b1, 10'h057, 8'h00);
    repeat (10) @(posedge clk_i);
    n = rcnt;
    repeat (1200) @(posedge clk_i);
    chk(rcnt, n);
    finish_test;
  end
endmodule
